/* core/sst_bucket.sv */
`timescale 1ns/1ps
`default_nettype none

module sst_bucket (
  // programmed mantissa
  input wire logic [6:0] mant_in,
  input wire logic zero_is_zero_in,
  // effective time in ms
  output logic [6:0] ms_out
);

  // ----------------------------------------
  // round each mantissa range to its supported bucket
  // ----------------------------------------
  function automatic logic [6:0] sst_round(input logic [6:0] m, input logic z);
    logic [6:0] r;
    r = 7'h64;
    if (m == 7'h00) begin
      r = z ? 7'h00 : 7'h01;
    end else if (m <= 7'h06) begin
      r = m;
    end else if (m <= 7'h09) begin
      r = 7'h07;
    end else if (m <= 7'h0c) begin
      r = 7'h0a;
    end else if (m <= 7'h11) begin
      r = 7'h0e;
    end else if (m <= 7'h16) begin
      r = 7'h13;
    end else if (m <= 7'h20) begin
      r = 7'h1b;
    end else if (m <= 7'h2c) begin
      r = 7'h25;
    end else if (m <= 7'h3e) begin
      r = 7'h34;
    end else if (m <= 7'h56) begin
      r = 7'h48;
    end
    return r;
  endfunction

  assign ms_out = sst_round(mant_in, zero_is_zero_in);

endmodule

`default_nettype wire

/* core/sst_map.svh */
`ifndef SST_MAP_SVH
`define SST_MAP_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define SST_CMD_FALL 8'h65
`define SST_CMD_SUMMARY 8'h78

// ----------------------------------------
// fall-time word layout and reset
// ----------------------------------------
`define SST_FALL_MANT_LSB 0
`define SST_FALL_MANT_MSB 6
`define SST_FALL_EXP_LSB 11
`define SST_FALL_EXP_MSB 15
`define SST_FALL_RESET 7'h03

// ----------------------------------------
// summary byte layout and reset
// ----------------------------------------
`define SST_SUM_OFF 6
`define SST_SUM_OVF 5
`define SST_SUM_OCF 4
`define SST_SUM_TEMP 2
`define SST_SUM_CML 1
`define SST_SUM_OTHER 0
`define SST_SUM_RESET 8'h01
`define SST_SRC_FAULT_BIT 7
`define SST_LOW_VIN_BIT 3

// ----------------------------------------
// timing
// ----------------------------------------
`define SST_CLK_PERIOD_NS 4
`define SST_MS_NS 1000000
`define SST_MS_CYCLES (`SST_MS_NS / `SST_CLK_PERIOD_NS)

`endif

/* core/sst_pkg.sv */
`default_nettype none
package sst_pkg;

  // command strobe from the protocol engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } sst_cmd_t;

  // answer to one command
  typedef struct packed {
    logic valid;
    logic nack;
    logic [15:0] rdata;
  } sst_rsp_t;

  // detailed status registers, owned elsewhere
  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] temp;
    logic [7:0] comm_logic_flag;
    logic [7:0] input_st;
    logic [7:0] vendor;
  } sst_status_t;

  typedef enum logic [2:0] {
    SST_IDLE = 3'b001,
    SST_DELAY = 3'b010,
    SST_FALL = 3'b100
  } sst_seq_t;

endpackage
`default_nettype wire

/* core/sst_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sst_map.svh"

module sst_top #(
  parameter int unsigned MS_CYCLES = `SST_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // strap and converter state
  input wire logic loop_follower_in,
  input wire logic converter_enabled_in,
  // command port
  input wire sst_pkg::sst_cmd_t cmd_in,
  output sst_pkg::sst_rsp_t rsp_out,
  output logic invalid_command_fault_out,
  output logic alert_out,
  // detailed status sources
  input wire sst_pkg::sst_status_t status_in,
  output logic [7:0] fault_summary_out,
  // nonvolatile storage
  input wire logic nv_store_in,
  input wire logic nv_restore_in,
  input wire logic [6:0] nv_data_in,
  output logic nv_write_out,
  output logic [6:0] nv_data_out,
  // soft stop
  input wire logic stop_in,
  input wire logic [6:0] stop_delay_time_in,
  output logic delay_active_out,
  output logic fall_active_out,
  output logic [6:0] fall_ms_out,
  output logic stop_done_out
);

  import sst_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic strap_taken;
    logic follower;
    logic [6:0] fall_mant;
    logic [7:0] summary;
    sst_rsp_t rsp;
    logic invalid_command_fault;
    logic alert;
    logic nv_write;
    logic [6:0] nv_data;
    sst_seq_t seq;
    logic [17:0] tick_cnt;
    logic [6:0] ms_left;
    logic [6:0] fall_ms;
    logic delay_active;
    logic fall_active;
    logic stop_done;
  } sst_state_t;

  sst_state_t st_reg;
  sst_state_t st_next;

  logic [6:0] fall_eff;
  logic [6:0] delay_eff;
  logic tick;
  logic other_src;
  logic [7:0] summary_now;
  logic fall_hit;
  logic sum_hit;

  localparam logic [17:0] TICK_LAST = 18'(MS_CYCLES - 1);

  // ----------------------------------------
  // bucket rounding
  // ----------------------------------------
  sst_bucket u_fall_bucket (
    .mant_in(st_reg.fall_mant),
    .zero_is_zero_in(1'b0),
    .ms_out(fall_eff)
  );

  sst_bucket u_delay_bucket (
    .mant_in(stop_delay_time_in),
    .zero_is_zero_in(1'b1),
    .ms_out(delay_eff)
  );

  // ----------------------------------------
  // summary sources
  // ----------------------------------------
  // other: undervoltage, warnings, turn-on timeout, input and vendor flags
  assign other_src = (|status_in.vout[6:2]) |
                     status_in.iout[5] |
                     (|status_in.input_st) |
                     (|status_in.vendor);

  always_comb begin
    summary_now = 8'h00;
    summary_now[`SST_SUM_OFF] = ~converter_enabled_in;
    summary_now[`SST_SUM_OVF] = status_in.vout[`SST_SRC_FAULT_BIT] &
                                ~st_reg.follower;
    summary_now[`SST_SUM_OCF] = status_in.iout[`SST_SRC_FAULT_BIT];
    summary_now[`SST_SUM_TEMP] = |status_in.temp;
    summary_now[`SST_SUM_CML] = |status_in.comm_logic_flag;
    summary_now[`SST_SUM_OTHER] = other_src;
  end

  assign tick = (st_reg.tick_cnt == TICK_LAST);
  assign fall_hit = cmd_in.valid && (cmd_in.code == `SST_CMD_FALL);
  assign sum_hit = cmd_in.valid && (cmd_in.code == `SST_CMD_SUMMARY);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rsp = '0;
    st_next.invalid_command_fault = 1'b0;
    st_next.alert = 1'b0;
    st_next.nv_write = 1'b0;
    st_next.stop_done = 1'b0;

    // strap is caught on the first clocked cycle after release
    if (!st_reg.strap_taken) begin
      st_next.strap_taken = 1'b1;
      st_next.follower = loop_follower_in;
    end

    // summary follows its sources; no write path exists
    if (st_reg.strap_taken) begin
      st_next.summary = summary_now;
    end

    // nonvolatile copy and restore
    if (nv_store_in) begin
      st_next.nv_write = 1'b1;
      st_next.nv_data = st_reg.fall_mant;
    end
    if (nv_restore_in && !st_reg.follower) begin
      st_next.fall_mant = nv_data_in;
    end

    // fall-time command
    if (fall_hit) begin
      st_next.rsp.valid = 1'b1;
      if (st_reg.follower) begin
        st_next.rsp.nack = 1'b1;
        st_next.invalid_command_fault = 1'b1;
        st_next.alert = 1'b1;
      end else if (cmd_in.write) begin
        // exponent and upper mantissa bits are dropped, never stored
        st_next.fall_mant = cmd_in.wdata[`SST_FALL_MANT_MSB:`SST_FALL_MANT_LSB];
      end else begin
        st_next.rsp.rdata = {9'h000, st_reg.fall_mant};
      end
    end

    // summary command: reads only
    if (sum_hit) begin
      st_next.rsp.valid = 1'b1;
      if (cmd_in.write) begin
        st_next.rsp.nack = 1'b1;
      end else begin
        st_next.rsp.rdata = {8'h00, st_reg.summary};
      end
    end

    // millisecond divider, restarted at each stop so phases are whole ms
    if (tick) begin
      st_next.tick_cnt = 18'h00000;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 18'h00001;
    end

    // soft-stop sequencer
    case (st_reg.seq)
      SST_IDLE: begin
        if (stop_in) begin
          st_next.tick_cnt = 18'h00000;
          st_next.fall_ms = fall_eff;
          if (delay_eff == 7'h00) begin
            st_next.seq = SST_FALL;
            st_next.ms_left = fall_eff;
            st_next.fall_active = 1'b1;
          end else begin
            st_next.seq = SST_DELAY;
            st_next.ms_left = delay_eff;
            st_next.delay_active = 1'b1;
          end
        end
      end
      SST_DELAY: begin
        if (tick) begin
          if (st_reg.ms_left == 7'h01) begin
            st_next.seq = SST_FALL;
            st_next.ms_left = st_reg.fall_ms;
            st_next.delay_active = 1'b0;
            st_next.fall_active = 1'b1;
          end else begin
            st_next.ms_left = st_reg.ms_left - 7'h01;
          end
        end
      end
      SST_FALL: begin
        if (tick) begin
          if (st_reg.ms_left == 7'h01) begin
            st_next.seq = SST_IDLE;
            st_next.ms_left = 7'h00;
            st_next.fall_active = 1'b0;
            st_next.stop_done = 1'b1;
          end else begin
            st_next.ms_left = st_reg.ms_left - 7'h01;
          end
        end
      end
      default: begin
        st_next.seq = SST_IDLE;
        st_next.delay_active = 1'b0;
        st_next.fall_active = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg <= '0;
      st_reg.fall_mant <= `SST_FALL_RESET;
      st_reg.summary <= `SST_SUM_RESET;
      st_reg.seq <= SST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rsp_out = st_reg.rsp;
  assign invalid_command_fault_out = st_reg.invalid_command_fault;
  assign alert_out = st_reg.alert;
  assign fault_summary_out = st_reg.summary;
  assign nv_write_out = st_reg.nv_write;
  assign nv_data_out = st_reg.nv_data;
  assign delay_active_out = st_reg.delay_active;
  assign fall_active_out = st_reg.fall_active;
  assign fall_ms_out = st_reg.fall_ms;
  assign stop_done_out = st_reg.stop_done;

endmodule

`default_nettype wire

/* testbench/sst_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sst_checker #(
  parameter int unsigned MS_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic loop_follower_in,
  input wire logic converter_enabled_in,
  input wire sst_pkg::sst_cmd_t cmd_in,
  input wire sst_pkg::sst_rsp_t rsp_out,
  input wire logic invalid_command_fault_out,
  input wire logic alert_out,
  input wire sst_pkg::sst_status_t status_in,
  input wire logic [7:0] fault_summary_out,
  input wire logic nv_store_in,
  input wire logic nv_write_out,
  input wire logic stop_in,
  input wire logic delay_active_out,
  input wire logic fall_active_out,
  input wire logic [6:0] fall_ms_out,
  input wire logic stop_done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // summary lags status by one cycle only from the second edge on
  logic [1:0] up_reg;
  logic [31:0] fall_cnt_reg;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      up_reg <= 2'h0;
      fall_cnt_reg <= '0;
    end else begin
      if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
      fall_cnt_reg <= fall_active_out ? fall_cnt_reg + 1 : '0;
    end
  end
  wire fall_cmd = cmd_in.valid && cmd_in.code == 8'h65;
  property p_rsp;
    cmd_in.valid && (cmd_in.code == 8'h65 || cmd_in.code == 8'h78) |=> rsp_out.valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_fol;
    fall_cmd && loop_follower_in |=> rsp_out.nack && invalid_command_fault_out && alert_out;
  endproperty
  a_fol: assert property (p_fol) else $error("follower access not refused");
  property p_ro;
    cmd_in.valid && cmd_in.write && cmd_in.code == 8'h78 |=> rsp_out.nack;
  endproperty
  a_ro: assert property (p_ro) else $error("summary write taken");
  property p_resv;
    !fault_summary_out[7] && !fault_summary_out[3];
  endproperty
  a_resv: assert property (p_resv) else $error("unused summary bit set");
  property p_ovf;
    up_reg == 2'h3 |-> fault_summary_out[5] == ($past(status_in.vout[7]) && !loop_follower_in);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overvoltage bit wrong");
  property p_ocf;
    up_reg == 2'h3 |-> fault_summary_out[4] == $past(status_in.iout[7]);
  endproperty
  a_ocf: assert property (p_ocf) else $error("overcurrent bit wrong");
  property p_temp;
    up_reg == 2'h3 |-> fault_summary_out[2] == |$past(status_in.temp);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature bit wrong");
  property p_cml;
    up_reg == 2'h3 |-> fault_summary_out[1] == |$past(status_in.comm_logic_flag);
  endproperty
  a_cml: assert property (p_cml) else $error("comm bit wrong");
  property p_off;
    up_reg == 2'h3 |-> fault_summary_out[6] == !$past(converter_enabled_in);
  endproperty
  a_off: assert property (p_off) else $error("off bit wrong");
  property p_stop;
    stop_in && !delay_active_out && !fall_active_out |=> delay_active_out || fall_active_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not started");
  property p_fall;
    stop_done_out |-> fall_cnt_reg == fall_ms_out * MS_CYCLES;
  endproperty
  a_fall: assert property (p_fall) else $error("fall length wrong");
  property p_nv;
    nv_store_in |=> nv_write_out;
  endproperty
  a_nv: assert property (p_nv) else $error("store not written");
  c_fol: cover property (fall_cmd && loop_follower_in ##1 rsp_out.nack);
  c_done: cover property (stop_done_out);
  c_ro: cover property (cmd_in.valid && cmd_in.write && cmd_in.code == 8'h78);
endmodule
bind sst_top sst_checker #(.MS_CYCLES(MS_CYCLES)) sst_checker_i (
  .clk_in(clk_in), .reset_in(reset_in), .loop_follower_in(loop_follower_in),
  .converter_enabled_in(converter_enabled_in), .cmd_in(cmd_in), .rsp_out(rsp_out),
  .invalid_command_fault_out(invalid_command_fault_out), .alert_out(alert_out),
  .status_in(status_in), .fault_summary_out(fault_summary_out),
  .nv_store_in(nv_store_in), .nv_write_out(nv_write_out), .stop_in(stop_in),
  .delay_active_out(delay_active_out), .fall_active_out(fall_active_out),
  .fall_ms_out(fall_ms_out), .stop_done_out(stop_done_out));
`default_nettype wire

/* testbench/sst_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sst_host (
  // clock
  input wire logic clk_in,
  // command port
  input wire sst_pkg::sst_rsp_t rsp_in,
  output var sst_pkg::sst_cmd_t cmd_out
);
  import sst_pkg::*;
  initial cmd_out = '0;
  // released lines show inverted data, so a stale word never looks valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output sst_rsp_t r);
    @(negedge clk_in);
    cmd_out = '{1'b1, w, c, d};
    @(negedge clk_in);
    cmd_out = '{1'b0, ~w, ~c, ~d};
    r = rsp_in;
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sst_pkg::*;
  localparam int unsigned MS = 4;
  logic clk_in, reset_in, fol, en, nv_st, nv_rs, stop, invalid_command_fault, alrt, nv_wr, d_act, f_act, done;
  logic [6:0] nv_di, dly, nv_do, fms;
  logic [7:0] sum;
  sst_cmd_t cmd;
  sst_rsp_t rsp, r;
  sst_status_t st;
  int errors, cmp_count, dc, fc;
  // ----------------------------------------
  // rows: write word, effective fall ms
  // ----------------------------------------
  logic [22:0] rows [13] = '{{16'h0000, 7'd1}, {16'h0006, 7'd6}, {16'h0007, 7'd7},
    {16'h0009, 7'd7}, {16'h000a, 7'd10}, {16'h0016, 7'd19}, {16'h0017, 7'd27},
    {16'h0020, 7'd27}, {16'h002c, 7'd37}, {16'h003e, 7'd52}, {16'h0056, 7'd72},
    {16'h0057, 7'd100}, {16'hffff, 7'd100}};
  logic [6:0] dv [5] = '{7'd23, 7'd33, 7'd45, 7'd63, 7'd87};
  logic [6:0] de [5] = '{7'd27, 7'd37, 7'd52, 7'd72, 7'd100};
  sst_top #(.MS_CYCLES(MS)) sst_top_i (.clk_in(clk_in), .reset_in(reset_in),
    .loop_follower_in(fol), .converter_enabled_in(en), .cmd_in(cmd), .rsp_out(rsp),
    .invalid_command_fault_out(invalid_command_fault), .alert_out(alrt), .status_in(st),
    .fault_summary_out(sum), .nv_store_in(nv_st), .nv_restore_in(nv_rs),
    .nv_data_in(nv_di), .nv_write_out(nv_wr), .nv_data_out(nv_do), .stop_in(stop),
    .stop_delay_time_in(dly), .delay_active_out(d_act), .fall_active_out(f_act),
    .fall_ms_out(fms), .stop_done_out(done));
  sst_host sst_host_i (.clk_in(clk_in), .rsp_in(rsp), .cmd_out(cmd));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic f);
    @(negedge clk_in);
    reset_in = 1'b1;
    fol = f;
    repeat (12) @(negedge clk_in);
    chk(16'(sum), 16'h0001);
    reset_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_in);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
  endtask
  // bounded wait, so a stuck sequencer shows as a wrong count
  task automatic stp(input logic [6:0] d);
    dc = 0;
    fc = 0;
    dly = d;
    pulse(stop);
    for (int i = 0; i < 2000 && !done; i++) begin
      dc += int'(d_act);
      fc += int'(f_act);
      @(negedge clk_in);
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    {fol, nv_st, nv_rs, stop, nv_di, dly, st} = '0;
    // reset from time zero, so no edge ever sees unknown state
    reset_in = 1'b1;
    en = 1'b1;
    rst(1'b0);
    sst_host_i.xfer(1'b0, 8'h65, 16'h0, r);
    chk(r.rdata, 16'h0003);
    foreach (rows[i]) begin
      sst_host_i.xfer(1'b1, 8'h65, rows[i][22:7], r);
      chk(16'({r.valid, r.nack}), 16'h0002);
      sst_host_i.xfer(1'b0, 8'h65, 16'h0, r);
      chk(r.rdata, {9'h0, rows[i][13:7]});
      stp(7'd0);
      chk(16'(fms), 16'(rows[i][6:0]));
      chk(16'(fc), 16'(rows[i][6:0] * MS));
    end
    sst_host_i.xfer(1'b1, 8'h65, 16'h0, r);
    foreach (dv[i]) begin
      stp(dv[i]);
      chk(16'(dc), 16'(de[i] * MS));
    end
    // ----------------------------------------
    // summary byte
    // ----------------------------------------
    st = '{8'h80, 8'h80, 8'h10, 8'h02, 8'h00, 8'h00};
    en = 1'b0;
    sst_host_i.xfer(1'b0, 8'h78, 16'h0, r);
    chk(r.rdata, 16'h0076);
    sst_host_i.xfer(1'b1, 8'h78, 16'h0, r);
    chk(16'({r.nack, invalid_command_fault, alrt}), 16'h0004);
    sst_host_i.xfer(1'b0, 8'h78, 16'h0, r);
    chk(r.rdata, 16'h0076);
    st = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
    en = 1'b1;
    sst_host_i.xfer(1'b0, 8'h78, 16'h0, r);
    chk(r.rdata, 16'h0001);
    nv_di = 7'h11;
    pulse(nv_rs);
    sst_host_i.xfer(1'b0, 8'h65, 16'h0, r);
    chk(r.rdata, 16'h0011);
    pulse(nv_st);
    chk(16'({nv_wr, nv_do}), 16'h0091);
    // follower strap: fall command refused and write dropped
    rst(1'b1);
    sst_host_i.xfer(1'b1, 8'h65, 16'h0005, r);
    chk(16'({r.valid, r.nack, invalid_command_fault, alrt}), 16'h000f);
    sst_host_i.xfer(1'b0, 8'h65, 16'h0, r);
    chk(16'({r.valid, r.nack, invalid_command_fault, alrt}), 16'h000f);
    pulse(nv_st);
    chk(16'({nv_wr, nv_do}), 16'h0083);
    st.vout = 8'h80;
    repeat (2) @(negedge clk_in);
    chk(16'(sum[5]), 16'h0);
    finish_test();
  end
endmodule
`default_nettype wire
